// [logic/fsp_pkg.sv]
// How it works
// - Suspend taken only with suspend flag 0, busy 1, during sector/block erase or program.
// - Suspend arriving during a whole-chip erase is ignored.
// - While erase is suspended, status write and every erase opcode are not executed.
// - While program is suspended, status write and every program opcode are not executed.
// - Program suspension honoured only for single-lane or four-lane page program.
// - Accepted suspend sets the suspend flag at once; busy drops within suspend latency.
// - While suspended, reads and permitted operations on other sectors still run.
// - Resume taken only with suspend flag 1 and busy 0.
// - Accepted resume clears suspend flag at once, raises busy, finishes the operation.
// - Resume after power loss during suspension is ignored.
// - Power-down acts only on exactly eight bits, then entered within the entry time.
// - Powered down, only the release opcode is recognised; all else is ignored.
// - After power is applied the device is in normal operation.
// - Release is the bare opcode; instructions accepted only after the release wait time.
// - Release opcode plus three dummy bytes returns the device code, repeating, MSB first.
// - Release and identification opcode ignored while busy; running cycle unaffected.
// - Single-lane identification: opcode, 24-bit zero address, then maker and device codes.
// - Dual-lane identification: address two bits per clock, codes two bits per clock, alternating.
// - Busy stays 1 for the whole self-timed cycle and clears when it ends.
package fsp_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CORE_CLK_PERIOD_NS = 5;
	localparam int TMR_W = 20;
	localparam int SUSPEND_LATENCY_NS = 20000;
	localparam int POWERDOWN_ENTRY_TIME_NS = 3000;
	localparam int RELEASE_WAIT_TIME_NS = 3000;
	localparam int RELEASE_ID_WAIT_TIME_NS = 1800;
	// Resume must raise busy within this bound; the core raises it on the third core edge after select rises
	localparam int RESUME_BUSY_NS = 200;

	// Longest times round down, never below one cycle
	function automatic int fsp_max_cycles(input int ns);
		int c;
		c = ns / CORE_CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [TMR_W-1:0] SUSPEND_LATENCY_CYC =
		TMR_W'(fsp_max_cycles(SUSPEND_LATENCY_NS));
	localparam logic [TMR_W-1:0] POWERDOWN_ENTRY_CYC =
		TMR_W'(fsp_max_cycles(POWERDOWN_ENTRY_TIME_NS));
	localparam logic [TMR_W-1:0] RELEASE_WAIT_CYC =
		TMR_W'(fsp_max_cycles(RELEASE_WAIT_TIME_NS));
	localparam logic [TMR_W-1:0] RELEASE_ID_WAIT_CYC =
		TMR_W'(fsp_max_cycles(RELEASE_ID_WAIT_TIME_NS));
	localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int CNT_W = 6;
	localparam int ADDR_W = 24;
	localparam int SHIFT_W = 32;
	localparam int SECT_HI = 23;
	localparam int SECT_LO = 12;
	localparam logic [CNT_W-1:0] CNT_OPCODE = 6'h08;
	localparam logic [CNT_W-1:0] CNT_WSR_MIN = 6'h10;
	localparam logic [CNT_W-1:0] CNT_DUAL_DATA = 6'h18;
	localparam logic [CNT_W-1:0] CNT_SINGLE_DATA = 6'h20;
	localparam logic [2:0] BYTE_ALIGN = 3'h0;

	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WSR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_CE_ALT = 8'h60;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_MFR_ID = 8'h90;
	localparam logic [7:0] OP_MFR_ID_DUAL = 8'h92;
	localparam logic [7:0] OP_RELEASE = 8'hAB;
	localparam logic [7:0] OP_PDOWN = 8'hB9;
	localparam logic [7:0] OP_CE = 8'hC7;
	localparam logic [7:0] OP_BE64 = 8'hD8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RUN = 3'b001,
		ST_SUSP_WAIT = 3'b010,
		ST_SUSP = 3'b011,
		ST_NEST = 3'b100,
		ST_PD_ENTER = 3'b101,
		ST_PD = 3'b110,
		ST_WAKE = 3'b111
	} fsp_state_t;

	typedef enum logic [1:0] {
		KIND_FIXED = 2'b00,
		KIND_ERASE = 2'b01,
		KIND_PROG = 2'b10
	} fsp_kind_t;

	function automatic logic fsp_is_erase(input logic [7:0] op);
		return op == OP_SE || op == OP_BE32 || op == OP_BE64 || op == OP_CE ||
			op == OP_CE_ALT || op == OP_SEC_ERASE;
	endfunction

	function automatic logic fsp_is_prog(input logic [7:0] op);
		return op == OP_PP || op == OP_QPP || op == OP_SEC_PROG;
	endfunction

	function automatic logic fsp_is_chip(input logic [7:0] op);
		return op == OP_CE || op == OP_CE_ALT;
	endfunction

	// Only these operations can later be suspended
	function automatic fsp_kind_t fsp_op_kind(input logic [7:0] op);
		if (op == OP_SE || op == OP_BE32 || op == OP_BE64) begin
			return KIND_ERASE;
		end
		if (op == OP_PP || op == OP_QPP) begin
			return KIND_PROG;
		end
		return KIND_FIXED;
	endfunction

endpackage

// [logic/fsp_link_if.sv]
interface fsp_link_if;
	import fsp_pkg::*;

	// Link side, stable once the serial clock has stopped
	logic [7:0] opcode;
	logic [ADDR_W-1:0] addr;
	logic [CNT_W-1:0] clk_cnt;
	logic long_frame;
	// Core side levels
	logic rel_id_ok;
	logic mfr_id_ok;

	modport link (
		output opcode,
		output addr,
		output clk_cnt,
		output long_frame,
		input rel_id_ok,
		input mfr_id_ok
	);

	modport core (
		input opcode,
		input addr,
		input clk_cnt,
		input long_frame,
		output rel_id_ok,
		output mfr_id_ok
	);
endinterface

// [logic/fsp_spi_link.sv]
module fsp_spi_link #(
	parameter logic [7:0] MFR_CODE = 8'hA5,
	parameter logic [7:0] DEV_CODE = 8'h3C
) (
	// Serial link
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic io0_in,
	input wire logic io1_in,
	output logic io0_out,
	output logic io0_oe,
	output logic io1_out,
	output logic io1_oe,
	// To the core
	fsp_link_if.link lk
);
	import fsp_pkg::*;

	// ----------------------------------------
	// Rising-edge capture
	// ----------------------------------------
	logic first_ff, nxt_first;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [SHIFT_W-1:0] sreg_ff, nxt_sreg;
	logic [7:0] op_ff, nxt_op;
	logic long_ff, nxt_long;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic go_ff, nxt_go;
	logic rel_s1_ff, rel_s2_ff, mfr_s1_ff, mfr_s2_ff;

	always_comb begin
		nxt_first = 1'b0;
		nxt_cnt = first_ff ? CNT_OPCODE - CNT_OPCODE + 6'h01 : cnt_ff + 6'h01;
		nxt_op = op_ff;
		// Cleared on the first clock of a frame, so it survives select rising
		nxt_long = first_ff ? 1'b0 : long_ff;
		nxt_addr = addr_ff;
		nxt_go = go_ff;
		if (!first_ff && op_ff == OP_MFR_ID_DUAL && cnt_ff >= CNT_OPCODE) begin
			nxt_sreg = {sreg_ff[SHIFT_W-3:0], io1_in, io0_in};
		end else begin
			nxt_sreg = {sreg_ff[SHIFT_W-2:0], io0_in};
		end
		if (nxt_cnt == CNT_OPCODE && !long_ff) begin
			nxt_op = nxt_sreg[7:0];
		end
		// Address is the 24 bits right after the opcode, not trailing data
		if (nxt_cnt == CNT_SINGLE_DATA && !long_ff) begin
			nxt_addr = nxt_sreg[ADDR_W-1:0];
		end
		if (nxt_cnt == CNT_SINGLE_DATA) begin
			nxt_long = 1'b1;
		end
		if (op_ff == OP_RELEASE && rel_s2_ff && nxt_cnt == CNT_SINGLE_DATA) begin
			nxt_go = 1'b1;
		end
		if (op_ff == OP_MFR_ID && mfr_s2_ff && nxt_cnt == CNT_SINGLE_DATA) begin
			nxt_go = 1'b1;
		end
		if (op_ff == OP_MFR_ID_DUAL && mfr_s2_ff && nxt_cnt == CNT_DUAL_DATA) begin
			nxt_go = 1'b1;
		end
	end

	// Select high restarts the frame, so a partial opcode never survives
	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			first_ff <= 1'b1;
			go_ff <= 1'b0;
			rel_s1_ff <= 1'b0;
			rel_s2_ff <= 1'b0;
			mfr_s1_ff <= 1'b0;
			mfr_s2_ff <= 1'b0;
		end else begin
			first_ff <= nxt_first;
			go_ff <= nxt_go;
			rel_s1_ff <= lk.rel_id_ok;
			rel_s2_ff <= rel_s1_ff;
			mfr_s1_ff <= lk.mfr_id_ok;
			mfr_s2_ff <= mfr_s1_ff;
		end
	end

	// Frame content is kept after select rises so the core can read it
	always_ff @(posedge spi_sclk) begin
		cnt_ff <= nxt_cnt;
		long_ff <= nxt_long;
		addr_ff <= nxt_addr;
		sreg_ff <= nxt_sreg;
		op_ff <= nxt_op;
	end

	assign lk.opcode = op_ff;
	assign lk.addr = addr_ff;
	assign lk.clk_cnt = cnt_ff;
	assign lk.long_frame = long_ff;

	// ----------------------------------------
	// Falling-edge output
	// ----------------------------------------
	logic [3:0] opos_ff, nxt_opos;
	logic [7:0] byte_sel;
	logic nxt_io0, nxt_io1, nxt_oe0, nxt_oe1;

	always_comb begin
		nxt_opos = opos_ff;
		nxt_io0 = 1'b0;
		nxt_io1 = 1'b0;
		nxt_oe0 = 1'b0;
		nxt_oe1 = 1'b0;
		byte_sel = opos_ff[3] ? DEV_CODE : MFR_CODE;
		if (op_ff == OP_RELEASE) begin
			byte_sel = DEV_CODE;
		end else if (op_ff == OP_MFR_ID_DUAL) begin
			byte_sel = opos_ff[2] ? DEV_CODE : MFR_CODE;
		end
		if (go_ff) begin
			nxt_opos = opos_ff + 4'h1;
			if (op_ff == OP_MFR_ID_DUAL) begin
				nxt_io1 = byte_sel[{~opos_ff[1:0], 1'b1}];
				nxt_io0 = byte_sel[{~opos_ff[1:0], 1'b0}];
				nxt_oe0 = 1'b1;
				nxt_oe1 = 1'b1;
			end else begin
				nxt_io1 = byte_sel[~opos_ff[2:0]];
				nxt_oe1 = 1'b1;
			end
		end
	end

	always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			opos_ff <= 4'h0;
			io0_out <= 1'b0;
			io1_out <= 1'b0;
			io0_oe <= 1'b0;
			io1_oe <= 1'b0;
		end else begin
			opos_ff <= nxt_opos;
			io0_out <= nxt_io0;
			io1_out <= nxt_io1;
			io0_oe <= nxt_oe0;
			io1_oe <= nxt_oe1;
		end
	end
endmodule

// [logic/fsp_top.sv]
module fsp_top #(
	parameter logic [fsp_pkg::TMR_W-1:0] OP_CYCLES = 20'h04E20,
	// Arbitrary identification values
	parameter logic [7:0] MFR_CODE = 8'hA5,
	parameter logic [7:0] DEV_CODE = 8'h3C
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Serial link
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic io0_in,
	input wire logic io1_in,
	output logic io0_out,
	output logic io0_oe,
	output logic io1_out,
	output logic io1_oe,
	// Status
	output logic busy,
	output logic suspend_status_flag,
	output logic powered_down,
	output fsp_pkg::fsp_kind_t suspended_kind
);
	import fsp_pkg::*;

	fsp_link_if lk ();

	fsp_spi_link #(
		.MFR_CODE(MFR_CODE),
		.DEV_CODE(DEV_CODE)
	) u_link (
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.io0_in(io0_in),
		.io1_in(io1_in),
		.io0_out(io0_out),
		.io0_oe(io0_oe),
		.io1_out(io1_out),
		.io1_oe(io1_oe),
		.lk(lk)
	);

	// ----------------------------------------
	// Frame end crossing
	// ----------------------------------------
	// Select rise is a level passed through two flops; the frame fields are
	// quasi-static by then because the serial clock has stopped.
	logic cs1_ff, cs2_ff, cs3_ff;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cs1_ff <= 1'b1;
			cs2_ff <= 1'b1;
			cs3_ff <= 1'b1;
		end else if (clk_en) begin
			cs1_ff <= spi_cs_n;
			cs2_ff <= cs1_ff;
			cs3_ff <= cs2_ff;
		end
	end

	logic frame_end;
	logic [7:0] op;
	logic exact8;
	logic aligned_long;
	logic wsr_ok;
	logic start_ok;
	logic other_sector;

	always_comb begin
		frame_end = cs2_ff && !cs3_ff;
		op = lk.opcode;
		// Power-down and control opcodes need select to rise right after bit 8
		exact8 = lk.clk_cnt == CNT_OPCODE && !lk.long_frame;
		aligned_long = lk.long_frame && lk.clk_cnt[2:0] == BYTE_ALIGN;
		wsr_ok = lk.clk_cnt[2:0] == BYTE_ALIGN &&
			(lk.long_frame || lk.clk_cnt >= CNT_WSR_MIN);
		if (fsp_is_chip(op)) begin
			start_ok = exact8;
		end else if (op == OP_WSR) begin
			start_ok = wsr_ok;
		end else begin
			start_ok = aligned_long && (fsp_is_erase(op) || fsp_is_prog(op));
		end
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	fsp_state_t state_ff, nxt_state;
	fsp_kind_t kind_ff, nxt_kind;
	logic [TMR_W-1:0] op_tmr_ff, nxt_op_tmr;
	logic [TMR_W-1:0] aux_tmr_ff, nxt_aux_tmr;
	logic [SECT_HI-SECT_LO:0] sect_ff, nxt_sect;
	logic nxt_busy, nxt_sus, nxt_pd, nxt_rel_ok, nxt_mfr_ok;
	logic rel_ok_ff, mfr_ok_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_op_tmr = op_tmr_ff;
		nxt_aux_tmr = aux_tmr_ff;
		nxt_sect = sect_ff;
		other_sector = lk.addr[SECT_HI:SECT_LO] != sect_ff;
		case (state_ff)
			ST_IDLE: begin
				if (frame_end) begin
					if (start_ok) begin
						nxt_state = ST_RUN;
						nxt_op_tmr = OP_CYCLES;
						nxt_kind = fsp_op_kind(op);
						nxt_sect = lk.addr[SECT_HI:SECT_LO];
					end else if (op == OP_PDOWN && exact8) begin
						nxt_state = ST_PD_ENTER;
						nxt_aux_tmr = POWERDOWN_ENTRY_CYC;
					end
				end
			end
			ST_RUN: begin
				if (op_tmr_ff == TMR_ONE) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_op_tmr = op_tmr_ff - TMR_ONE;
				end
				// Chip erase, status write and security ops carry no suspend kind
				if (frame_end && op == OP_SUSPEND && exact8 && kind_ff != KIND_FIXED &&
					op_tmr_ff != TMR_ONE) begin
					nxt_state = ST_SUSP_WAIT;
					nxt_aux_tmr = SUSPEND_LATENCY_CYC;
				end
			end
			ST_SUSP_WAIT: begin
				if (aux_tmr_ff == TMR_ONE) begin
					nxt_state = ST_SUSP;
				end else begin
					nxt_aux_tmr = aux_tmr_ff - TMR_ONE;
				end
			end
			ST_SUSP: begin
				if (frame_end) begin
					if (op == OP_RESUME && exact8) begin
						nxt_state = ST_RUN;
					end else if (start_ok && other_sector && !fsp_is_chip(op) &&
						op != OP_WSR &&
						!(kind_ff == KIND_ERASE && fsp_is_erase(op)) &&
						!(kind_ff == KIND_PROG && fsp_is_prog(op))) begin
						nxt_state = ST_NEST;
						nxt_aux_tmr = OP_CYCLES;
					end
				end
			end
			ST_NEST: begin
				// The interrupted operation stays parked; a second suspend is refused
				if (aux_tmr_ff == TMR_ONE) begin
					nxt_state = ST_SUSP;
				end else begin
					nxt_aux_tmr = aux_tmr_ff - TMR_ONE;
				end
			end
			ST_PD_ENTER: begin
				if (aux_tmr_ff == TMR_ONE) begin
					nxt_state = ST_PD;
				end else begin
					nxt_aux_tmr = aux_tmr_ff - TMR_ONE;
				end
			end
			ST_PD: begin
				if (frame_end && op == OP_RELEASE && (exact8 || lk.long_frame)) begin
					nxt_state = ST_WAKE;
					nxt_aux_tmr = exact8 ? RELEASE_WAIT_CYC : RELEASE_ID_WAIT_CYC;
				end
			end
			ST_WAKE: begin
				// Frames during the wait are dropped, so nothing is taken early
				if (aux_tmr_ff == TMR_ONE) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_aux_tmr = aux_tmr_ff - TMR_ONE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_busy = nxt_state == ST_RUN || nxt_state == ST_SUSP_WAIT ||
			nxt_state == ST_NEST;
		nxt_sus = nxt_state == ST_SUSP_WAIT || nxt_state == ST_SUSP ||
			nxt_state == ST_NEST;
		nxt_pd = nxt_state == ST_PD || nxt_state == ST_WAKE;
		nxt_rel_ok = nxt_state == ST_IDLE || nxt_state == ST_SUSP ||
			nxt_state == ST_PD;
		nxt_mfr_ok = nxt_state == ST_IDLE || nxt_state == ST_SUSP;
	end

	// Reset stands for power-up: awake, nothing suspended, so resume is refused
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			kind_ff <= KIND_FIXED;
			op_tmr_ff <= 20'h00000;
			aux_tmr_ff <= 20'h00000;
			sect_ff <= 12'h000;
			busy <= 1'b0;
			suspend_status_flag <= 1'b0;
			powered_down <= 1'b0;
			rel_ok_ff <= 1'b1;
			mfr_ok_ff <= 1'b1;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			op_tmr_ff <= nxt_op_tmr;
			aux_tmr_ff <= nxt_aux_tmr;
			sect_ff <= nxt_sect;
			busy <= nxt_busy;
			suspend_status_flag <= nxt_sus;
			powered_down <= nxt_pd;
			rel_ok_ff <= nxt_rel_ok;
			mfr_ok_ff <= nxt_mfr_ok;
		end
	end

	assign suspended_kind = kind_ff;
	assign lk.rel_id_ok = rel_ok_ff;
	assign lk.mfr_id_ok = mfr_ok_ff;
endmodule

// [bench/fsp_monitor.sv]
module fsp_monitor
	import fsp_pkg::*;
#(
	parameter logic [TMR_W-1:0] OP_CYCLES = 20'h04E20
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Serial link
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic io0_in,
	input wire logic io1_in,
	input wire logic io0_out,
	input wire logic io0_oe,
	input wire logic io1_out,
	input wire logic io1_oe,
	// Status
	input wire logic busy,
	input wire logic suspend_status_flag,
	input wire logic powered_down,
	input fsp_kind_t suspended_kind
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Run-length counters, frozen with the core
	// ----------------------------------------
	localparam int LAT_MAX = int'(SUSPEND_LATENCY_CYC) + 1;
	logic [TMR_W:0] bcnt_ff, nxt_bcnt, scnt_ff, nxt_scnt;

	always_comb begin
		nxt_bcnt = !clk_en ? bcnt_ff : (busy ? bcnt_ff + 1'b1 : '0);
		nxt_scnt = !clk_en ? scnt_ff : ((busy && suspend_status_flag) ? scnt_ff + 1'b1 : '0);
	end

	always_ff @(posedge core_clk) begin
		bcnt_ff <= reset ? '0 : nxt_bcnt;
		scnt_ff <= reset ? '0 : nxt_scnt;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_cs_quiet;
		spi_cs_n |-> !io0_oe && !io1_oe;
	endproperty
	property p_sus_needs_busy;
		$rose(suspend_status_flag) |-> $past(busy) && busy;
	endproperty
	property p_sus_kind;
		$rose(suspend_status_flag) |-> suspended_kind != KIND_FIXED;
	endproperty
	property p_sus_latency;
		scnt_ff <= (TMR_W + 1)'(LAT_MAX);
	endproperty
	property p_resume;
		$fell(suspend_status_flag) |-> !$past(busy) && busy;
	endproperty
	property p_kind_stable;
		suspend_status_flag && $past(suspend_status_flag) |-> $stable(suspended_kind);
	endproperty
	property p_pd_quiet;
		powered_down |-> !busy && !suspend_status_flag;
	endproperty
	property p_busy_bounded;
		bcnt_ff <= {1'b0, OP_CYCLES} + (TMR_W + 1)'(LAT_MAX + 16);
	endproperty
	property p_freeze;
		!clk_en |=> $stable(busy) && $stable(suspend_status_flag) && $stable(powered_down);
	endproperty

	a_cs_quiet: assert property (p_cs_quiet) else $error("drive while deselected");
	a_sus_needs_busy: assert property (p_sus_needs_busy) else $error("bad suspend");
	a_sus_kind: assert property (p_sus_kind) else $error("suspend of fixed op");
	a_sus_latency: assert property (p_sus_latency) else $error("suspend too slow");
	a_resume: assert property (p_resume) else $error("bad resume");
	a_kind_stable: assert property (p_kind_stable) else $error("kind changed");
	a_pd_quiet: assert property (p_pd_quiet) else $error("active in power-down");
	a_busy_bounded: assert property (p_busy_bounded) else $error("busy too long");
	a_freeze: assert property (p_freeze) else $error("status moved when frozen");

	c_suspend: cover property ($rose(suspend_status_flag));
	c_resume: cover property ($fell(suspend_status_flag));
	c_pdown: cover property ($rose(powered_down));
endmodule

bind fsp_top fsp_monitor #(.OP_CYCLES(OP_CYCLES)) u_fsp_monitor (.core_clk(core_clk),
	.reset(reset), .clk_en(clk_en), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
	.io0_in(io0_in), .io1_in(io1_in), .io0_out(io0_out), .io0_oe(io0_oe),
	.io1_out(io1_out), .io1_oe(io1_oe), .busy(busy),
	.suspend_status_flag(suspend_status_flag), .powered_down(powered_down),
	.suspended_kind(suspended_kind));

// [bench/fsp_spi_host.sv]
module fsp_spi_host (
	// Serial link
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic io0_in,
	output logic io1_in,
	input wire logic io0_out,
	input wire logic io0_oe,
	input wire logic io1_out,
	input wire logic io1_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b0;
		io0_in = 1'b0;
		io1_in = 1'b1;
		// A rising select at start clears the link's output flops
		#1 spi_cs_n = 1'b1;
	end

	// ----------------------------------------
	// One frame; clock stands still between frames
	// ----------------------------------------
	task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int nclk,
		input bit dual, input int nrd, output logic [31:0] rd);
		logic [39:0] w;
		w = {op, ad, 8'hF0};
		rd = '0;
		// Select stays high long enough for the core to see each frame end
		#27 spi_cs_n = 1'b0;
		#40;
		for (int i = 0; i < nclk; i++) begin
			if (dual && i >= 8) begin
				{io1_in, io0_in} = w[39:38];
				w = w << 2;
			end else begin
				io0_in = w[39];
				io1_in = ~io1_in;
				w = w << 1;
			end
			#40 spi_sclk = 1'b1;
			#40 spi_sclk = 1'b0;
		end
		for (int i = 0; i < nrd; i++) begin
			io0_in = ~io0_in;
			#40 spi_sclk = 1'b1;
			if (dual) begin
				rd = {rd[29:0], io1_oe & io1_out, io0_oe & io0_out};
			end else begin
				rd = {rd[30:0], io1_oe & io1_out};
			end
			#40 spi_sclk = 1'b0;
		end
		// Select rises only after a whole count of clocks
		#40 spi_cs_n = 1'b1;
		io0_in = ~io0_in;
	endtask
endmodule

// [bench/fsp_tb_top.sv]
module fsp_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fsp_pkg::*;

	// Cycle count shortened; identification values are arbitrary
	localparam logic [TMR_W-1:0] OPC = 20'h003E8;
	localparam logic [7:0] MFR = 8'h5A;
	localparam logic [7:0] DEV = 8'hC3;
	logic core_clk, reset, clk_en, spi_sclk, spi_cs_n, io0_in, io1_in;
	logic io0_out, io0_oe, io1_out, io1_oe, busy, suspend_status_flag, powered_down;
	fsp_kind_t suspended_kind;
	logic [31:0] rd;
	int failures, samples_checked, cycles;

	fsp_top #(.OP_CYCLES(OPC), .MFR_CODE(MFR), .DEV_CODE(DEV)) u_fsp_top (.core_clk(core_clk),
		.reset(reset), .clk_en(clk_en), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.io0_in(io0_in), .io1_in(io1_in), .io0_out(io0_out), .io0_oe(io0_oe),
		.io1_out(io1_out), .io1_oe(io1_oe), .busy(busy),
		.suspend_status_flag(suspend_status_flag), .powered_down(powered_down),
		.suspended_kind(suspended_kind));
	fsp_spi_host u_fsp_spi_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .io0_in(io0_in),
		.io1_in(io1_in), .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out),
		.io1_oe(io1_oe));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic end_sim;
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			end_sim();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic chk_st(input logic [2:0] exp);
		samples_checked++;
		if ({busy, suspend_status_flag, powered_down} !== exp) begin
			failures++;
			$display("Error at %0t: status %h expected %h", $time,
				{busy, suspend_status_flag, powered_down}, exp);
		end
	endtask

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: data %h expected %h", $time, got, exp);
		end
	endtask

	// Status settles within four core cycles of select rising
	task automatic fr(input logic [7:0] op, input logic [23:0] ad, input int n);
		u_fsp_spi_host.frame(op, ad, n, 1'b0, 0, rd);
		cyc(8);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_erase_suspend;
		fr(OP_SE, 24'h001000, 32); chk_st(3'b100);
		fr(OP_SUSPEND, 24'h000000, 8); chk_st(3'b110);
		chk_rd(32'(suspended_kind), 32'(KIND_ERASE));
		cyc(4010); chk_st(3'b010);
		fr(OP_SUSPEND, 24'h000000, 8); chk_st(3'b010);
		fr(OP_SE, 24'h002000, 32); chk_st(3'b010);
		fr(OP_WSR, 24'h000000, 16); chk_st(3'b010);
		fr(OP_PP, 24'h001800, 40); chk_st(3'b010);
		fr(OP_PP, 24'h002000, 40); chk_st(3'b110);
		fr(OP_RESUME, 24'h000000, 8); chk_st(3'b110);
		cyc(1010); chk_st(3'b010);
		fr(OP_RESUME, 24'h000000, 9); chk_st(3'b010);
		fr(OP_RESUME, 24'h000000, 8); chk_st(3'b100);
		cyc(1010); chk_st(3'b000);
		fr(OP_RESUME, 24'h000000, 8); chk_st(3'b000);
	endtask

	task automatic t_chip;
		fr(OP_CE, 24'h000000, 8); chk_st(3'b100);
		fr(OP_SUSPEND, 24'h000000, 8); chk_st(3'b100);
		clk_en = 1'b0;
		cyc(1100); chk_st(3'b100);
		clk_en = 1'b1;
		cyc(1010); chk_st(3'b000);
	endtask

	task automatic t_prog;
		fr(OP_PP, 24'h003000, 40); chk_st(3'b100);
		fr(OP_SUSPEND, 24'h000000, 8); chk_st(3'b110);
		chk_rd(32'(suspended_kind), 32'(KIND_PROG));
		cyc(4010); chk_st(3'b010);
		fr(OP_QPP, 24'h004000, 40); chk_st(3'b010);
		fr(OP_WSR, 24'h000000, 16); chk_st(3'b010);
		// Reset stands in for loss of power while suspended
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		chk_st(3'b000);
		fr(OP_RESUME, 24'h000000, 8); chk_st(3'b000);
	endtask

	task automatic t_pdown;
		fr(OP_PDOWN, 24'h000000, 5); cyc(610); chk_st(3'b000);
		fr(OP_PDOWN, 24'h000000, 16); cyc(610); chk_st(3'b000);
		fr(OP_PDOWN, 24'h000000, 8); chk_st(3'b000);
		cyc(600); chk_st(3'b001);
		fr(OP_SE, 24'h001000, 32); chk_st(3'b001);
		u_fsp_spi_host.frame(OP_MFR_ID, 24'h000000, 32, 1'b0, 16, rd);
		chk_rd(rd, 32'h00000000);
		fr(OP_RELEASE, 24'h000000, 8); chk_st(3'b001);
		cyc(600); chk_st(3'b000);
		fr(OP_PDOWN, 24'h000000, 8); cyc(600); chk_st(3'b001);
		u_fsp_spi_host.frame(OP_RELEASE, 24'h000000, 32, 1'b0, 16, rd);
		chk_rd(rd, {16'h0000, DEV, DEV});
		cyc(8); chk_st(3'b001);
		cyc(int'(RELEASE_ID_WAIT_CYC)); chk_st(3'b000);
	endtask

	task automatic t_ids;
		u_fsp_spi_host.frame(OP_RELEASE, 24'h000000, 32, 1'b0, 16, rd);
		chk_rd(rd, {16'h0000, DEV, DEV});
		cyc(8);
		u_fsp_spi_host.frame(OP_MFR_ID, 24'h000000, 32, 1'b0, 16, rd);
		chk_rd(rd, {16'h0000, MFR, DEV});
		cyc(8);
		u_fsp_spi_host.frame(OP_MFR_ID_DUAL, 24'h000000, 24, 1'b1, 16, rd);
		chk_rd(rd, {MFR, DEV, MFR, DEV});
		cyc(8);
		fr(OP_SE, 24'h005000, 32); chk_st(3'b100);
		u_fsp_spi_host.frame(OP_RELEASE, 24'h000000, 32, 1'b0, 16, rd);
		chk_rd(rd, 32'h00000000);
		cyc(8); chk_st(3'b100);
		cyc(1010); chk_st(3'b000);
	endtask

	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc(1); chk_st(3'b000);
		t_erase_suspend();
		t_chip();
		t_prog();
		t_pdown();
		t_ids();
		end_sim();
	end
endmodule
